// >>> hdl/fcr_pkg.sv
package fcr_pkg;
   localparam int          REG_W      = 16;
   localparam int          COEFF_W    = 12;
   localparam int          COEFF_MSB  = 11;
   localparam int          NUM_REGS   = 4;
   localparam int          ADDR_W     = 14;
   localparam int          IDX_W      = 12;
   localparam logic [15:0] REG_RST    = 16'h0000;
   // register indices; byte address is four times the index
   localparam logic [11:0] IDX_TAP5   = 12'h423;
   localparam logic [11:0] IDX_TAP6   = 12'h425;
   localparam logic [11:0] IDX_TAP7   = 12'h427;
   localparam logic [11:0] IDX_TAP8   = 12'h429;

   typedef logic signed [COEFF_W-1:0] fcr_coeff_t;
   typedef struct packed {
      fcr_coeff_t tap8;
      fcr_coeff_t tap7;
      fcr_coeff_t tap6;
      fcr_coeff_t tap5;
   } fcr_taps_t;
   typedef struct packed {
      logic       hit;
      logic [1:0] sel;
   } fcr_dec_t;

   function automatic logic [ADDR_W-1:0] fcr_byte_addr(input logic [IDX_W-1:0] idx);
      return {idx, 2'b00};
   endfunction

   function automatic fcr_dec_t fcr_decode(input logic [ADDR_W-1:0] addr);
      fcr_dec_t d;
      d = '{hit: 1'b1, sel: 2'd0};
      if (addr == fcr_byte_addr(IDX_TAP5)) d.sel = 2'd0;
      else if (addr == fcr_byte_addr(IDX_TAP6)) d.sel = 2'd1;
      else if (addr == fcr_byte_addr(IDX_TAP7)) d.sel = 2'd2;
      else if (addr == fcr_byte_addr(IDX_TAP8)) d.sel = 2'd3;
      else d.hit = 1'b0;
      return d;
   endfunction

   // readback drops the coefficient msb, storage keeps it
   function automatic logic [REG_W-1:0] fcr_readback(input logic [REG_W-1:0] r);
      logic [REG_W-1:0] v;
      v            = r;
      v[COEFF_MSB] = 1'b0;
      return v;
   endfunction
endpackage

// >>> hdl/fcr_tap_regs.sv
`timescale 1ns/100ps
module fcr_tap_regs (
   input  wire logic                          pclk,
   input  wire logic                          presetn,
   input  wire logic                          psel,
   input  wire logic                          penable,
   input  wire logic                          pwrite,
   input  wire logic [fcr_pkg::ADDR_W-1:0]    paddr,
   input  wire logic [31:0]                   pwdata,
   output logic      [31:0]                   prdata,
   output logic                               pready,
   output logic                               pslverr,
   input  wire logic                          single_chan_mode,
   output fcr_pkg::fcr_taps_t                 chan_a_taps,
   output fcr_pkg::fcr_taps_t                 single_taps
);
   import fcr_pkg::*;

   logic [NUM_REGS-1:0][REG_W-1:0] regs_q, regs_d;
   logic [31:0]                    prdata_q, prdata_d;
   logic                           err_q, err_d;
   fcr_taps_t                      chan_a_q, chan_a_d, single_q, single_d;
   fcr_taps_t                      taps_now;
   fcr_dec_t                       dec;
   logic                           wr_acc, setup;

   assign dec     = fcr_decode(paddr);
   assign setup   = psel && !penable;
   assign wr_acc  = psel && penable && pwrite;
   // zero wait states: read data is latched in the setup cycle
   assign pready  = 1'b1;
   assign pslverr = psel && penable && err_q;
   assign prdata  = prdata_q;

   always_comb begin
      regs_d   = regs_q;
      prdata_d = prdata_q;
      err_d    = err_q;
      if (wr_acc && dec.hit) begin
         regs_d[dec.sel] = pwdata[REG_W-1:0];
      end
      if (setup) begin
         err_d    = !dec.hit;
         prdata_d = '0;
         if (dec.hit && !pwrite) begin
            prdata_d[REG_W-1:0] = fcr_readback(regs_q[dec.sel]);
         end
      end
   end

   always_comb begin
      taps_now.tap5 = regs_q[0][COEFF_W-1:0];
      taps_now.tap6 = regs_q[1][COEFF_W-1:0];
      taps_now.tap7 = regs_q[2][COEFF_W-1:0];
      taps_now.tap8 = regs_q[3][COEFF_W-1:0];
      // unused destination held at zero so the idle filter sees no taps
      chan_a_d = single_chan_mode ? '0 : taps_now;
      single_d = single_chan_mode ? taps_now : '0;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         regs_q   <= {NUM_REGS{REG_RST}};
         prdata_q <= '0;
         err_q    <= 1'b0;
         chan_a_q <= '0;
         single_q <= '0;
      end else begin
         regs_q   <= regs_d;
         prdata_q <= prdata_d;
         err_q    <= err_d;
         chan_a_q <= chan_a_d;
         single_q <= single_d;
      end
   end

   assign chan_a_taps = chan_a_q;
   assign single_taps = single_q;

   a_reset_zero: assert property (@(posedge pclk)
      $rose(presetn) |-> (regs_q == '0 && chan_a_q == '0 && single_q == '0))
      else $error("registers not zero after reset");

   a_write_store: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_acc && dec.hit) |=> regs_q[$past(dec.sel)] == $past(pwdata[REG_W-1:0]))
      else $error("written value not stored");

   a_tap6_drive: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && penable && pwrite && paddr == fcr_byte_addr(IDX_TAP5)
       && !single_chan_mode ##1 !single_chan_mode)
      |=> chan_a_taps.tap5 == $past(pwdata[COEFF_W-1:0], 2))
      else $error("sixth tap not driven by its register");

   a_tap7_drive: assert property (@(posedge pclk) disable iff (!presetn)
      !$past(single_chan_mode) |-> chan_a_taps.tap6 == $past(regs_q[1][COEFF_W-1:0]))
      else $error("seventh tap mismatch");

   a_tap8_drive: assert property (@(posedge pclk) disable iff (!presetn)
      $past(single_chan_mode) |-> single_taps.tap7 == $past(regs_q[2][COEFF_W-1:0]))
      else $error("eighth tap mismatch");

   a_tap9_drive: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_acc && paddr == fcr_byte_addr(IDX_TAP8)) ##1 single_chan_mode
      |=> single_taps.tap8 == $past(pwdata[COEFF_W-1:0], 2))
      else $error("ninth tap mismatch");

   a_single_mode: assert property (@(posedge pclk) disable iff (!presetn)
      $past(single_chan_mode) |-> (chan_a_taps == '0
                                   && single_taps == $past(taps_now)))
      else $error("single mode routing wrong");

   a_msb_hidden: assert property (@(posedge pclk) disable iff (!presetn)
      (setup && !pwrite && dec.hit) |=>
      (prdata[COEFF_MSB] == 1'b0 && prdata[REG_W-1:COEFF_MSB+1]
       == $past(regs_q[dec.sel][REG_W-1:COEFF_MSB+1])
       && prdata[COEFF_MSB-1:0] == $past(regs_q[dec.sel][COEFF_MSB-1:0])))
      else $error("readback msb not masked");

   a_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
      (setup && !dec.hit) ##1 (psel && penable) |-> pslverr ##1 $stable(regs_q))
      else $error("unmapped access not refused");

   // reset state, checked while reset is held
   a_reset_regs: assert property (@(posedge pclk)
      !presetn |->
      (regs_q == '0 && prdata == '0 && !pslverr))
      else $error("register or read data not zero in reset");

   a_reset_taps: assert property (@(posedge pclk)
      !presetn |->
      (chan_a_taps == '0 && single_taps == '0))
      else $error("tap outputs not zero in reset");

   // storage, one register per address
   a_store_tap5: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_acc && paddr == fcr_byte_addr(IDX_TAP5)) |=>
      regs_q[0] == $past(pwdata[REG_W-1:0]))
      else $error("sixth tap register not written");

   a_store_tap6: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_acc && paddr == fcr_byte_addr(IDX_TAP6)) |=>
      regs_q[1] == $past(pwdata[REG_W-1:0]))
      else $error("seventh tap register not written");

   a_store_tap7: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_acc && paddr == fcr_byte_addr(IDX_TAP7)) |=>
      regs_q[2] == $past(pwdata[REG_W-1:0]))
      else $error("eighth tap register not written");

   a_store_tap8: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_acc && paddr == fcr_byte_addr(IDX_TAP8)) |=>
      regs_q[3] == $past(pwdata[REG_W-1:0]))
      else $error("ninth tap register not written");

   a_rsvd_stored: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_acc && dec.hit) |=>
      regs_q[$past(dec.sel)][REG_W-1:COEFF_W] == $past(pwdata[REG_W-1:COEFF_W]))
      else $error("reserved bits not stored");

   a_msb_stored: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_acc && dec.hit) |=>
      regs_q[$past(dec.sel)][COEFF_MSB] == $past(pwdata[COEFF_MSB]))
      else $error("coefficient msb not kept in storage");

   // a write touches its own register and no other
   a_keep_tap5: assert property (@(posedge pclk) disable iff (!presetn)
      !(wr_acc && dec.hit && dec.sel == 2'd0) |=>
      $stable(regs_q[0]))
      else $error("sixth tap register changed without a write");

   a_keep_tap6: assert property (@(posedge pclk) disable iff (!presetn)
      !(wr_acc && dec.hit && dec.sel == 2'd1) |=>
      $stable(regs_q[1]))
      else $error("seventh tap register changed without a write");

   a_keep_tap7: assert property (@(posedge pclk) disable iff (!presetn)
      !(wr_acc && dec.hit && dec.sel == 2'd2) |=>
      $stable(regs_q[2]))
      else $error("eighth tap register changed without a write");

   a_keep_tap8: assert property (@(posedge pclk) disable iff (!presetn)
      !(wr_acc && dec.hit && dec.sel == 2'd3) |=>
      $stable(regs_q[3]))
      else $error("ninth tap register changed without a write");

   a_read_keeps: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && penable && !pwrite) |=>
      $stable(regs_q))
      else $error("read access changed a register");

   a_idle_keeps: assert property (@(posedge pclk) disable iff (!presetn)
      !psel |=>
      $stable(regs_q))
      else $error("register changed while bus idle");

   a_bad_write_ignored: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_acc && !dec.hit) |=>
      $stable(regs_q))
      else $error("unmapped write changed a register");

   // readback per register, msb forced low
   a_read_tap5: assert property (@(posedge pclk) disable iff (!presetn)
      (setup && !pwrite && paddr == fcr_byte_addr(IDX_TAP5)) |=>
      (prdata[REG_W-1:0] == {$past(regs_q[0][REG_W-1:COEFF_MSB+1]), 1'b0,
                             $past(regs_q[0][COEFF_MSB-1:0])}))
      else $error("sixth tap readback wrong");

   a_read_tap6: assert property (@(posedge pclk) disable iff (!presetn)
      (setup && !pwrite && paddr == fcr_byte_addr(IDX_TAP6)) |=>
      (prdata[REG_W-1:0] == {$past(regs_q[1][REG_W-1:COEFF_MSB+1]), 1'b0,
                             $past(regs_q[1][COEFF_MSB-1:0])}))
      else $error("seventh tap readback wrong");

   a_read_tap7: assert property (@(posedge pclk) disable iff (!presetn)
      (setup && !pwrite && paddr == fcr_byte_addr(IDX_TAP7)) |=>
      (prdata[REG_W-1:0] == {$past(regs_q[2][REG_W-1:COEFF_MSB+1]), 1'b0,
                             $past(regs_q[2][COEFF_MSB-1:0])}))
      else $error("eighth tap readback wrong");

   a_read_tap8: assert property (@(posedge pclk) disable iff (!presetn)
      (setup && !pwrite && paddr == fcr_byte_addr(IDX_TAP8)) |=>
      (prdata[REG_W-1:0] == {$past(regs_q[3][REG_W-1:COEFF_MSB+1]), 1'b0,
                             $past(regs_q[3][COEFF_MSB-1:0])}))
      else $error("ninth tap readback wrong");

   a_rdata_upper: assert property (@(posedge pclk) disable iff (!presetn)
      1'b1 |->
      prdata[31:REG_W] == '0)
      else $error("read data upper half not zero");

   a_write_no_rdata: assert property (@(posedge pclk) disable iff (!presetn)
      (setup && pwrite) |=>
      prdata == '0)
      else $error("write setup left stale read data");

   a_rdata_hold: assert property (@(posedge pclk) disable iff (!presetn)
      !setup |=>
      $stable(prdata))
      else $error("read data changed outside setup");

   // refusal of unmapped addresses
   a_bad_read_zero: assert property (@(posedge pclk) disable iff (!presetn)
      (setup && !dec.hit) |=>
      prdata == '0)
      else $error("unmapped read not zero");

   a_mapped_no_err: assert property (@(posedge pclk) disable iff (!presetn)
      (setup && dec.hit) ##1 (psel && penable) |->
      !pslverr)
      else $error("mapped access flagged as error");

   a_err_access_only: assert property (@(posedge pclk) disable iff (!presetn)
      !(psel && penable) |->
      !pslverr)
      else $error("error flag outside access phase");

   a_err_one_cycle: assert property (@(posedge pclk) disable iff (!presetn)
      pslverr |=>
      !pslverr)
      else $error("error flag held past its access");

   // tap routing for the taps not covered above
   a_dual_tap5: assert property (@(posedge pclk) disable iff (!presetn)
      !$past(single_chan_mode) |->
      chan_a_taps.tap5 == $past(regs_q[0][COEFF_W-1:0]))
      else $error("dual mode sixth tap mismatch");

   a_dual_tap7: assert property (@(posedge pclk) disable iff (!presetn)
      !$past(single_chan_mode) |->
      chan_a_taps.tap7 == $past(regs_q[2][COEFF_W-1:0]))
      else $error("dual mode eighth tap mismatch");

   a_dual_tap8: assert property (@(posedge pclk) disable iff (!presetn)
      !$past(single_chan_mode) |->
      chan_a_taps.tap8 == $past(regs_q[3][COEFF_W-1:0]))
      else $error("dual mode ninth tap mismatch");

   a_single_tap5: assert property (@(posedge pclk) disable iff (!presetn)
      $past(single_chan_mode) |->
      single_taps.tap5 == $past(regs_q[0][COEFF_W-1:0]))
      else $error("single mode sixth tap mismatch");

   a_single_tap6: assert property (@(posedge pclk) disable iff (!presetn)
      $past(single_chan_mode) |->
      single_taps.tap6 == $past(regs_q[1][COEFF_W-1:0]))
      else $error("single mode seventh tap mismatch");

   a_single_tap8: assert property (@(posedge pclk) disable iff (!presetn)
      $past(single_chan_mode) |->
      single_taps.tap8 == $past(regs_q[3][COEFF_W-1:0]))
      else $error("single mode ninth tap mismatch");

   a_dual_idle: assert property (@(posedge pclk) disable iff (!presetn)
      !$past(single_chan_mode) |->
      single_taps == '0)
      else $error("combined filter taps not idle in dual mode");

   c_reserved_write: cover property (@(posedge pclk) disable iff (!presetn)
      wr_acc && dec.hit && pwdata[REG_W-1:COEFF_W] != '0);
   c_write_read: cover property (@(posedge pclk) disable iff (!presetn)
      wr_acc && dec.hit ##1 setup && !pwrite && dec.hit);
   c_mode_switch: cover property (@(posedge pclk) disable iff (!presetn)
      $rose(single_chan_mode));
   c_msb_write: cover property (@(posedge pclk) disable iff (!presetn)
      wr_acc && dec.hit && pwdata[COEFF_MSB]);
   c_slverr: cover property (@(posedge pclk) disable iff (!presetn) pslverr);
endmodule

// >>> verification/fcr_tap_regs_tb.sv
`timescale 1ns/100ps
module fcr_tap_regs_tb;
   import fcr_pkg::*;
   logic              pclk = 0, presetn = 1, psel = 0, penable = 0, pwrite = 0;
   logic              single_chan_mode = 0, pready, pslverr, err;
   logic [ADDR_W-1:0] paddr = '0;
   logic [31:0]       pwdata = '0, prdata, rd;
   fcr_taps_t         chan_a_taps, single_taps, exp_t;
   int                n_mismatch = 0, num_checks = 0, cyc = 0;
   logic [15:0]       val [4] = '{16'hA9E5, 16'h5801, 16'hF7FF, 16'h0C3A};
   logic [11:0]       idx [4] = '{IDX_TAP5, IDX_TAP6, IDX_TAP7, IDX_TAP8};

   fcr_tap_regs i_fcr_tap_regs (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .single_chan_mode(single_chan_mode), .chan_a_taps(chan_a_taps),
      .single_taps(single_taps));

   always #5 pclk = ~pclk;
   // whole run needs about 63 cycles
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         n_mismatch++;
         stop_test();
      end
   end

   task stop_test;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   task chk(input string nm, input logic [47:0] e, input logic [47:0] g);
      num_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask

   // upper pwdata half set on purpose: it must be ignored
   task apb(input logic w, input logic [11:0] ix, input logic [15:0] d);
      @(posedge pclk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= {ix, 2'b00}; pwdata <= {16'hFFFF, d};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task t_reset;
      for (int i = 0; i < 4; i++) begin
         apb(1'b0, idx[i], 16'h0000);
         chk("reset read", 48'h0, {16'h0, rd});
      end
      chk("reset taps", 48'h0, chan_a_taps | single_taps);
   endtask

   task t_rw;
      for (int i = 0; i < 4; i++) apb(1'b1, idx[i], val[i]);
      for (int i = 0; i < 4; i++) begin
         apb(1'b0, idx[i], 16'h0000);
         // msb masked out of the expectation, as software must do
         chk("readback", {32'h0, val[i] & 16'hF7FF}, {16'h0, rd});
         chk("read err", 48'h0, {47'h0, err});
      end
   endtask

   task t_taps(input logic m);
      single_chan_mode <= m;
      repeat (2) @(posedge pclk);
      #1;
      exp_t = {val[3][11:0], val[2][11:0], val[1][11:0], val[0][11:0]};
      chk("chan a taps", m ? 48'h0 : exp_t, chan_a_taps);
      chk("single taps", m ? exp_t : 48'h0, single_taps);
   endtask

   task t_bad;
      apb(1'b1, IDX_TAP5 + 12'h001, 16'h0123);
      chk("bad write err", 48'h1, {47'h0, err});
      apb(1'b0, IDX_TAP5 + 12'h001, 16'h0000);
      chk("bad read", 48'h1, {15'h0, rd, err});
      apb(1'b0, IDX_TAP5, 16'h0000);
      chk("tap5 kept", {32'h0, val[0] & 16'hF7FF}, {16'h0, rd});
   endtask

   initial begin
      // a real falling edge, so the asynchronous reset branch runs at time zero
      presetn <= 1'b0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_rw();
      t_taps(1'b0);
      t_taps(1'b1);
      t_bad();
      t_taps(1'b0);
      stop_test();
   end
endmodule
